// ===== hdl/crcwl_config_top.sv
/*
  CRC width, length and polynomial configuration with the input FIFO and
  a Wishbone classic slave; instantiates the serial shifter.
  Assumes a single 200 MHz clock and a Wishbone master with 32-bit data.
*/
// Operation
// RQ1 - The data width field sits in bits 12..8 of the width/length register and a word is field+1 bits wide.
// RQ2 - The polynomial length field sits in bits 4..0 of that register and the polynomial is field+1 long.
// RQ3 - Bits 15..13 and 7..5 of the width/length register are unimplemented and read zero.
// RQ4 - Bits 15..1 of the low polynomial register enable the feedback term of the same exponent.
// RQ5 - Bit 0 of the low polynomial register does not exist and reads zero; the constant term needs no enable.
// RQ6 - Bits 15..0 of the high polynomial register enable terms 31..16.
// RQ7 - All implemented configuration bits are read/write and clear to zero on reset.
// RQ8 - The constant term and the top term implied by the length are always applied.
// RQ9 - FIFO depth is four words for width field above 15, eight for 8..15, sixteen below 8.
// RQ10 - When started with words queued, the shifter does two bits a cycle until the FIFO is empty.
// RQ11 - Writes to unimplemented bit positions change nothing.
`timescale 1ns/10ps
`include "crcwl_regs.svh"
module crcwl_config_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Engine status
  output logic crcBusy
);

  crcwl_eng_if eng ();

  logic [15:0] widthLenCtrl_reg;
  logic [15:0] polyLow_reg;
  logic [15:0] polyHigh_reg;
  logic engineEnable_reg;
  logic shifterGo_reg;
  logic [31:0] fifoMem [0:15];
  logic [3:0] wrPtr_reg;
  logic [3:0] rdPtr_reg;
  logic [4:0] count_reg;
  logic [4:0] fifoDepth;
  logic fifoFull;
  logic fifoEmpty;
  logic access;
  logic writeEn;
  logic push;
  logic pop;
  logic [31:0] readValue;

  // Byte-lane merge; bits outside the mask never store
  function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [15:0] wdat,
                                            input logic [1:0] sel, input logic [15:0] mask);
    logic [15:0] laneMask;
    laneMask = {{8{sel[1]}}, {8{sel[0]}}};
    mergeLanes = ((old & ~laneMask) | (wdat & laneMask)) & mask;
  endfunction : mergeLanes

  // Depth chosen by the data width field
  function automatic logic [4:0] depthFor(input logic [4:0] widthSel);
    if (widthSel > `CRCWL_WIDE_LIMIT) begin
      depthFor = `CRCWL_DEPTH_WIDE;
    end else if (widthSel >= `CRCWL_MID_LIMIT) begin
      depthFor = `CRCWL_DEPTH_MID;
    end else begin
      depthFor = `CRCWL_DEPTH_NARROW;
    end
  endfunction : depthFor

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Answer one cycle after the request; the gap also lets the master drop stb
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign writeEn = access && wb_we_i;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  always_comb begin
    readValue = 32'h00000000;
    case (wb_adr_i)
      `CRCWL_OFF_WLC: readValue = {16'h0000, widthLenCtrl_reg & `CRCWL_WLC_MASK}; // RQ3
      `CRCWL_OFF_PLO: readValue = {16'h0000, polyLow_reg & `CRCWL_PLO_MASK}; // RQ5
      `CRCWL_OFF_PHI: readValue = {16'h0000, polyHigh_reg};
      `CRCWL_OFF_CTL: begin
        readValue[`CRCWL_CTL_ENABLE] = engineEnable_reg;
        readValue[`CRCWL_CTL_CNT_MSB:`CRCWL_CTL_CNT_LSB] = count_reg;
        readValue[`CRCWL_CTL_FULL] = fifoFull;
        readValue[`CRCWL_CTL_EMPTY] = fifoEmpty;
        readValue[`CRCWL_CTL_GO] = shifterGo_reg;
      end
      `CRCWL_OFF_RES: readValue = eng.crcValue;
      default: readValue = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h00000000;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= readValue;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      widthLenCtrl_reg <= `CRCWL_WLC_RESET; // RQ7
      polyLow_reg <= `CRCWL_PLO_RESET;
      polyHigh_reg <= `CRCWL_PHI_RESET;
    end else if (writeEn) begin
      case (wb_adr_i)
        `CRCWL_OFF_WLC: widthLenCtrl_reg <= mergeLanes(widthLenCtrl_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                                                       `CRCWL_WLC_MASK); // RQ11
        `CRCWL_OFF_PLO: polyLow_reg <= mergeLanes(polyLow_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                                                  `CRCWL_PLO_MASK); // RQ11
        `CRCWL_OFF_PHI: polyHigh_reg <= mergeLanes(polyHigh_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                                                   `CRCWL_PHI_MASK);
        default: begin
        end
      endcase
    end
  end

  assign eng.dataWidthSel = widthLenCtrl_reg[`CRCWL_WIDTH_MSB:`CRCWL_WIDTH_LSB]; // RQ1
  assign eng.polyLengthSel = widthLenCtrl_reg[`CRCWL_LEN_MSB:`CRCWL_LEN_LSB]; // RQ2
  assign eng.polyTerms = {polyHigh_reg, polyLow_reg[15:1], 1'b0}; // RQ4 RQ6

  // ----------------------------------------------------------------
  // Enable and start control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      engineEnable_reg <= 1'b0;
    end else if (writeEn && wb_adr_i == `CRCWL_OFF_CTL && wb_sel_i[1]) begin
      engineEnable_reg <= wb_dat_i[`CRCWL_CTL_ENABLE];
    end
  end

  // A software write in the same cycle as the hardware stop wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shifterGo_reg <= 1'b0;
    end else if (writeEn && wb_adr_i == `CRCWL_OFF_CTL && wb_sel_i[0]) begin
      shifterGo_reg <= wb_dat_i[`CRCWL_CTL_GO];
    end else if (!engineEnable_reg || (fifoEmpty && !eng.busy && !push)) begin
      shifterGo_reg <= 1'b0; // RQ10
    end
  end

  assign eng.engineEnable = engineEnable_reg;
  assign eng.shifterGo = shifterGo_reg;
  assign eng.crcClear = writeEn && wb_adr_i == `CRCWL_OFF_RES;
  assign crcBusy = eng.busy;

  // ----------------------------------------------------------------
  // Input FIFO
  // ----------------------------------------------------------------
  assign fifoDepth = depthFor(eng.dataWidthSel); // RQ9
  assign fifoFull = count_reg >= fifoDepth; // RQ9
  assign fifoEmpty = count_reg == 5'h00;
  // Writes into a full FIFO are dropped; software polls the full flag
  assign push = writeEn && wb_adr_i == `CRCWL_OFF_DAT && engineEnable_reg && !fifoFull;
  assign pop = eng.wordTaken;
  assign eng.wordValid = !fifoEmpty; // RQ10
  assign eng.wordData = fifoMem[rdPtr_reg];

  always_ff @(posedge mclk) begin
    if (push) begin
      fifoMem[wrPtr_reg] <= wb_dat_i;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrPtr_reg <= 4'h0;
      rdPtr_reg <= 4'h0;
      count_reg <= 5'h00;
    end else if (!engineEnable_reg) begin
      wrPtr_reg <= 4'h0;
      rdPtr_reg <= 4'h0;
      count_reg <= 5'h00;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 4'h1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 4'h1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 5'h01;
      end else if (pop && !push) begin
        count_reg <= count_reg - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  crcwl_shifter shifter (
    .mclk(mclk),
    .reset(reset),
    .eng(eng.engine)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_WIDTH_FIELD: assert property ( // RQ1
    writeEn && wb_adr_i == `CRCWL_OFF_WLC && wb_sel_i[1] |=> eng.dataWidthSel == $past(wb_dat_i[12:8]))
    else $error("width field not taken from bits 12..8");

  AST_LENGTH_FIELD: assert property ( // RQ2
    writeEn && wb_adr_i == `CRCWL_OFF_WLC && wb_sel_i[0] |=> eng.polyLengthSel == $past(wb_dat_i[4:0]))
    else $error("length field not taken from bits 4..0");

  AST_WLC_GAPS_ZERO: assert property ( // RQ3
    wb_ack_o && !wb_we_i && wb_adr_i == `CRCWL_OFF_WLC |-> wb_dat_o[15:13] == 3'h0 && wb_dat_o[7:5] == 3'h0)
    else $error("unimplemented width/length bits read nonzero");

  AST_LOW_TERMS: assert property ( // RQ4
    writeEn && wb_adr_i == `CRCWL_OFF_PLO && wb_sel_i == 4'hF |=> eng.polyTerms[15:1] == $past(wb_dat_i[15:1]))
    else $error("low term enables not mapped by exponent");

  AST_LOW_BIT0_ZERO: assert property ( // RQ5
    wb_ack_o && !wb_we_i && wb_adr_i == `CRCWL_OFF_PLO |-> wb_dat_o[0] == 1'b0)
    else $error("low polynomial bit 0 read nonzero");

  AST_HIGH_TERMS: assert property ( // RQ6
    writeEn && wb_adr_i == `CRCWL_OFF_PHI && wb_sel_i == 4'hF |=> eng.polyTerms[31:16] == $past(wb_dat_i[15:0]))
    else $error("high term enables not mapped to terms 31..16");

  AST_RESET_CLEAR: assert property ( // RQ7
    $past(reset) |-> widthLenCtrl_reg == 16'h0000 && polyLow_reg == 16'h0000 && polyHigh_reg == 16'h0000)
    else $error("configuration not zero after reset");

  AST_FULL_DROPS: assert property ( // RQ9
    writeEn && wb_adr_i == `CRCWL_OFF_DAT && engineEnable_reg && count_reg >= fifoDepth && !pop
    |=> count_reg == $past(count_reg))
    else $error("write into full FIFO was stored");

  AST_UNIMPL_WRITE: assert property ( // RQ11
    writeEn && (wb_adr_i == `CRCWL_OFF_WLC || wb_adr_i == `CRCWL_OFF_PLO)
    |=> widthLenCtrl_reg[15:13] == 3'h0 && widthLenCtrl_reg[7:5] == 3'h0 && polyLow_reg[0] == 1'b0)
    else $error("write reached an unimplemented bit");

endmodule : crcwl_config_top

// ===== hdl/crcwl_shifter.sv
/*
  Serial CRC shifter: takes one word from the FIFO and shifts it, MSb first,
  two bits per cycle through a Galois register of programmable length.
  Assumes the configuration stays stable while a word is shifted.
*/
`timescale 1ns/10ps
module crcwl_shifter (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link to the configuration block
  crcwl_eng_if.engine eng
);

  crcwl_pkg::crcwl_shift_state_type state_reg;
  logic [31:0] shiftWord_reg;
  logic [5:0] remain_reg;
  logic [31:0] crc_reg;
  logic [31:0] polyFull;
  logic [31:0] crcOne;
  logic [31:0] crcTwo;
  logic take;

  // One bit step; the top term X^N is the feedback tap itself
  function automatic logic [31:0] crcStep(input logic [31:0] crc, input logic din,
                                          input logic [31:0] poly, input logic [4:0] top);
    logic [31:0] mask;
    logic [31:0] nxt;
    mask = 32'hFFFFFFFF >> (5'h1F - top);
    nxt = {crc[30:0], 1'b0};
    if (crc[top] ^ din) begin
      nxt = nxt ^ poly;
    end
    crcStep = nxt & mask;
  endfunction : crcStep

  assign polyFull = {eng.polyTerms[31:1], 1'b1}; // RQ8
  assign take = (state_reg == crcwl_pkg::SHIFT_IDLE) && eng.engineEnable && eng.shifterGo && eng.wordValid;
  assign eng.wordTaken = take;
  assign eng.busy = (state_reg == crcwl_pkg::SHIFT_RUN);
  assign eng.crcValue = crc_reg;
  assign crcOne = crcStep(crc_reg, shiftWord_reg[31], polyFull, eng.polyLengthSel); // RQ2
  assign crcTwo = (remain_reg >= 6'h02) ? crcStep(crcOne, shiftWord_reg[30], polyFull, eng.polyLengthSel) : crcOne;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= crcwl_pkg::SHIFT_IDLE;
      remain_reg <= 6'h00;
      shiftWord_reg <= 32'h00000000;
    end else if (!eng.engineEnable) begin
      state_reg <= crcwl_pkg::SHIFT_IDLE;
      remain_reg <= 6'h00;
    end else begin
      case (state_reg)
        crcwl_pkg::SHIFT_IDLE: begin
          if (take) begin
            state_reg <= crcwl_pkg::SHIFT_RUN;
            remain_reg <= {1'b0, eng.dataWidthSel} + 6'h01; // RQ1
            shiftWord_reg <= eng.wordData << (5'h1F - eng.dataWidthSel);
          end
        end
        crcwl_pkg::SHIFT_RUN: begin
          shiftWord_reg <= {shiftWord_reg[29:0], 2'b00}; // RQ10
          if (remain_reg <= 6'h02) begin
            remain_reg <= 6'h00;
            state_reg <= crcwl_pkg::SHIFT_IDLE;
          end else begin
            remain_reg <= remain_reg - 6'h02;
          end
        end
        default: begin
          state_reg <= crcwl_pkg::SHIFT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // CRC result
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      crc_reg <= 32'h00000000;
    end else if (!eng.engineEnable || eng.crcClear) begin
      crc_reg <= 32'h00000000;
    end else if (state_reg == crcwl_pkg::SHIFT_RUN) begin
      crc_reg <= crcTwo; // RQ10
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [5:0] busyCnt_reg;
  logic [5:0] wantCnt_reg;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busyCnt_reg <= 6'h00;
      wantCnt_reg <= 6'h00;
    end else if (take) begin
      busyCnt_reg <= 6'h00;
      wantCnt_reg <= ({1'b0, eng.dataWidthSel} + 6'h02) >> 1;
    end else if (eng.busy) begin
      busyCnt_reg <= busyCnt_reg + 6'h01;
    end
  end

  AST_TWO_BITS_PER_CYCLE: assert property (@(posedge mclk) disable iff (reset) // RQ10
    eng.engineEnable && $fell(eng.busy) |-> busyCnt_reg == wantCnt_reg)
    else $error("word shift took the wrong number of cycles");

endmodule : crcwl_shifter

// ===== inc/crcwl_eng_if.sv
/*
  Carrier between the configuration/FIFO block and the serial shifter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface crcwl_eng_if;
  logic engineEnable;
  logic shifterGo;
  logic [4:0] dataWidthSel;
  logic [4:0] polyLengthSel;
  logic [31:0] polyTerms;
  logic wordValid;
  logic [31:0] wordData;
  logic wordTaken;
  logic busy;
  logic crcClear;
  logic [31:0] crcValue;

  modport control (
    output engineEnable, shifterGo, dataWidthSel, polyLengthSel, polyTerms,
    output wordValid, wordData, crcClear,
    input wordTaken, busy, crcValue
  );
  modport engine (
    input engineEnable, shifterGo, dataWidthSel, polyLengthSel, polyTerms,
    input wordValid, wordData, crcClear,
    output wordTaken, busy, crcValue
  );
endinterface : crcwl_eng_if

// ===== inc/crcwl_pkg.sv
/*
  Types of the CRC configuration block.
  Assumes nothing of its surroundings.
*/
package crcwl_pkg;
  typedef enum logic {SHIFT_IDLE, SHIFT_RUN} crcwl_shift_state_type;
endpackage : crcwl_pkg

// ===== inc/crcwl_regs.svh
/*
  Register offsets, field positions, masks, reset values and FIFO depth counts
  of the CRC width/length/polynomial configuration block.
  Assumes byte addressing on a 32-bit Wishbone bus, one register per word.
*/
`ifndef CRCWL_REGS_SVH
`define CRCWL_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define CRCWL_OFF_WLC 8'h00
`define CRCWL_OFF_PLO 8'h04
`define CRCWL_OFF_PHI 8'h08
`define CRCWL_OFF_CTL 8'h0C
`define CRCWL_OFF_DAT 8'h10
`define CRCWL_OFF_RES 8'h14

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CRCWL_WIDTH_MSB 12
`define CRCWL_WIDTH_LSB 8
`define CRCWL_LEN_MSB 4
`define CRCWL_LEN_LSB 0
`define CRCWL_CTL_ENABLE 15
`define CRCWL_CTL_CNT_MSB 12
`define CRCWL_CTL_CNT_LSB 8
`define CRCWL_CTL_FULL 7
`define CRCWL_CTL_EMPTY 6
`define CRCWL_CTL_GO 4

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define CRCWL_WLC_MASK 16'h1F1F
`define CRCWL_PLO_MASK 16'hFFFE
`define CRCWL_PHI_MASK 16'hFFFF
`define CRCWL_WLC_RESET 16'h0000
`define CRCWL_PLO_RESET 16'h0000
`define CRCWL_PHI_RESET 16'h0000

// ----------------------------------------------------------------
// FIFO depth by data width field
// ----------------------------------------------------------------
`define CRCWL_WIDE_LIMIT 5'h0F
`define CRCWL_MID_LIMIT 5'h08
`define CRCWL_DEPTH_WIDE 5'h04
`define CRCWL_DEPTH_MID 5'h08
`define CRCWL_DEPTH_NARROW 5'h10

`endif

// ===== sim/crc_width_polynomial_config_tb_top.sv
/*
  Self-checking bench of the CRC configuration block: register fields, FIFO depth,
  shifter timing through the crcBusy output, and CRC result, through the Wishbone classic slave.
  Assumes the register map and one-wait-state bus timing of the configuration block.
*/
`timescale 1ns/10ps
`include "crcwl_regs.svh"
module crc_width_polynomial_config_tb_top;
  localparam int CYCLE_LIMIT = 20000;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [31:0] wbDatO;
  logic wbAck;
  logic crcBusy;
  int numErrors = 0;
  int numChecks = 0;
  int cycleCount = 0;

  always #2.5 mclk = ~mclk;

  crcwl_config_top i_crcwl_config_top (
    .mclk(mclk),
    .reset(reset),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck),
    .crcBusy(crcBusy)
  );

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic wrapUp();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrapUp

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // A hang anywhere ends in the same report
  always @(posedge mclk) begin
    cycleCount++;
    if (cycleCount == CYCLE_LIMIT) begin
      numErrors++;
      wrapUp();
    end
  end

  // ----------------------------------------------------------------
  // Wishbone classic master
  // ----------------------------------------------------------------
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatI <= wdat;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rdat = wbDatO;
    if (n >= 50) begin
      numErrors++;
      $display("mismatch ack expected 1 seen none at %h", adr);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, dat, d);
  endtask : wr

  task automatic rd(input logic [7:0] adr, output logic [31:0] dat);
    bus(1'b0, adr, 32'h0000_0000, dat);
  endtask : rd

  // ----------------------------------------------------------------
  // Reference CRC: MSb first, X0 and the top term always applied
  // ----------------------------------------------------------------
  function automatic logic [31:0] crcRef(input logic [31:0] crc, input logic [31:0] word, input int w,
                                         input int n, input logic [31:0] poly);
    logic [31:0] mask;
    logic fb;
    mask = (n == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << n) - 32'h0000_0001);
    for (int i = w - 1; i >= 0; i--) begin
      fb = crc[n - 1] ^ word[i];
      crc = (crc << 1) & mask;
      if (fb) begin
        crc = crc ^ ((poly | 32'h0000_0001) & mask);
      end
    end
    return crc;
  endfunction : crcRef

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic regScenario();
    logic [31:0] d;
    logic [31:0] pat [3] = '{32'hFFFF_FFFF, 32'hA5A5_A5A5, 32'h5A5A_5A5A};
    rd(`CRCWL_OFF_WLC, d);
    check("wlc reset", 32'h0000_0000, d);
    rd(`CRCWL_OFF_PLO, d);
    check("plo reset", 32'h0000_0000, d);
    rd(`CRCWL_OFF_PHI, d);
    check("phi reset", 32'h0000_0000, d);
    foreach (pat[i]) begin
      wr(`CRCWL_OFF_WLC, pat[i]);
      wr(`CRCWL_OFF_PLO, pat[i]);
      wr(`CRCWL_OFF_PHI, pat[i]);
      wr(8'h18, pat[i]);
      rd(`CRCWL_OFF_WLC, d);
      check("wlc", pat[i] & 32'h0000_1F1F, d);
      rd(`CRCWL_OFF_PLO, d);
      check("plo", pat[i] & 32'h0000_FFFE, d);
      rd(`CRCWL_OFF_PHI, d);
      check("phi", pat[i] & 32'h0000_FFFF, d);
      rd(8'h18, d);
      check("unmapped", 32'h0000_0000, d);
    end
    // Reset in mid-run must clear what software left behind
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(`CRCWL_OFF_WLC, d);
    check("wlc second reset", 32'h0000_0000, d);
    rd(`CRCWL_OFF_PLO, d);
    check("plo second reset", 32'h0000_0000, d);
    rd(`CRCWL_OFF_PHI, d);
    check("phi second reset", 32'h0000_0000, d);
  endtask : regScenario

  task automatic depthCase(input logic [4:0] field, input int depth);
    logic [31:0] d;
    wr(`CRCWL_OFF_CTL, 32'h0000_0000);
    wr(`CRCWL_OFF_CTL, 32'h0000_8000);
    wr(`CRCWL_OFF_WLC, {19'h0, field, 8'h00});
    // One word more than fits, so the last push meets a full FIFO
    for (int i = 0; i <= depth; i++) begin
      wr(`CRCWL_OFF_DAT, 32'h0000_0100 + i);
    end
    rd(`CRCWL_OFF_CTL, d);
    check("fifo count", 32'(depth), {27'h0, d[12:8]});
    check("fifo full", 32'h0000_0001, {31'h0, d[7]});
    wr(`CRCWL_OFF_CTL, 32'h0000_0000);
    rd(`CRCWL_OFF_CTL, d);
    check("fifo count off", 32'h0000_0000, {27'h0, d[12:8]});
    check("fifo empty off", 32'h0000_0001, {31'h0, d[6]});
  endtask : depthCase

  task automatic crcRun(input logic [4:0] wfield, input logic [4:0] lfield, input logic [31:0] lo,
                        input logic [31:0] hi, input logic [31:0] w0, input logic [31:0] w1);
    logic [31:0] d;
    logic [31:0] exp;
    int run;
    int runs;
    int width;
    width = int'(wfield) + 1;
    run = 0;
    runs = 0;
    exp = crcRef(32'h0000_0000, w0, width, int'(lfield) + 1, {hi[15:0], lo[15:0]});
    exp = crcRef(exp, w1, width, int'(lfield) + 1, {hi[15:0], lo[15:0]});
    wr(`CRCWL_OFF_CTL, 32'h0000_8000);
    wr(`CRCWL_OFF_WLC, {19'h0, wfield, 3'h0, lfield});
    wr(`CRCWL_OFF_PLO, lo);
    wr(`CRCWL_OFF_PHI, hi);
    wr(`CRCWL_OFF_RES, 32'h0000_0000);
    wr(`CRCWL_OFF_DAT, w0);
    wr(`CRCWL_OFF_DAT, w1);
    wr(`CRCWL_OFF_CTL, 32'h0000_8010);
    // Each busy run is one word; two bits go through per cycle
    repeat (80) begin
      @(posedge mclk);
      if (crcBusy === 1'b1) begin
        run++;
      end else if (run > 0) begin
        runs++;
        check("busy cycles", 32'((width + 1) / 2), 32'(run));
        run = 0;
      end
    end
    check("busy runs", 32'h0000_0002, 32'(runs));
    rd(`CRCWL_OFF_RES, d);
    check("crc result", exp, d);
    rd(`CRCWL_OFF_CTL, d);
    check("fifo empty after run", 32'h0000_0001, {31'h0, d[6]});
  endtask : crcRun

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    regScenario();
    depthCase(5'h1F, 4);
    depthCase(5'h10, 4);
    depthCase(5'h0F, 8);
    depthCase(5'h08, 8);
    depthCase(5'h07, 16);
    depthCase(5'h00, 16);
    crcRun(5'h1F, 5'h1F, 32'h0000_1DB7, 32'h0000_04C1, 32'h1234_5678, 32'hFFFF_0000);
    crcRun(5'h07, 5'h0F, 32'h0000_1020, 32'h0000_0000, 32'h0000_00A5, 32'h0000_003C);
    crcRun(5'h0C, 5'h07, 32'h0000_0006, 32'h0000_FFFF, 32'h0000_1ABC, 32'h0000_0F0F);
    wrapUp();
  end
endmodule : crc_width_polynomial_config_tb_top
